// ### hdl/sdbt_core.sv
// sdbt_core.sv: transmit and receive dma channels in single buffer mode
//
// Contract
// RL1 - byte-only transfers on 8-bit bus or force bit
// RL2 - byte transfer: count minus one, address steps
// RL3 - 8-bit bus carries bytes on low lane
// RL4 - forced bytes: tx both lanes, rx by bit0; tx with step hold reads one lane by bit0
// RL5 - lane order follows latest lane command
// RL6 - word transfer when even address, count two up
// RL7 - odd address or count one: byte transfer
// RL8 - word transfer: count minus two, address by two
// RL9 - two fifo chars ordered on lanes by command
// RL10 - oldest frame-end char on even lane
// RL11 - tx counter one: final byte from low lane
// RL12 - move on request, end at zero count
// RL13 - early termination only when enabled
// RL14 - abort input stops channel at once
// RL15 - reset, pause, abort commands stop at once
// RL16 - single buffer mode stops after buffer end
// RL17 - tx termination in sync modes at zero count
// RL18 - frame boundary forces rx request until stored
// RL19 - rx char counter never terminates or forces
// RL20 - software loads address, count, then starts
// RL21 - address and count keep ending values
// RL22 - buffer end pulse and pollable done status
// RL23 - major mode codes select four modes; only the single buffer code starts a channel here
// RL24 - zero count start transfers nothing
// RL25 - count saturates at zero, never wraps
`timescale 1ns/1ns

module sdbt_core (
    input wire logic CORE_CLK,
    input wire logic RST_B,
    input wire logic WIDE_BUS_SELECT,
    input wire sdbt_pkg::sdbt_mode_t TX_MODE,
    input wire sdbt_pkg::sdbt_mode_t RX_MODE,
    input wire sdbt_pkg::sdbt_serial_mode_t SERIAL_MODE,
    input wire logic [1:0] LOAD_EN,
    input wire logic [31:0] LOAD_ADDR,
    input wire logic [15:0] LOAD_COUNT,
    input wire sdbt_pkg::sdbt_dma_cmd_t DMA_CMD,
    input wire logic DMA_CMD_ALL,
    input wire logic DMA_CMD_RX,
    input wire sdbt_pkg::sdbt_chan_cmd_t CHAN_CMD,
    input wire logic ABORT_B,
    input wire logic TX_REQ,
    input wire logic TXF_ROOM2,
    input wire logic [15:0] TX_CHAR_COUNT,
    input wire logic RX_REQ,
    input wire logic RXF_TWO,
    input wire logic [7:0] RXF_CHAR0,
    input wire logic [7:0] RXF_CHAR1,
    input wire logic [1:0] RXF_BOUND,
    input wire logic RXF_BOUND_IN,
    input wire logic RX_TERM,
    input wire logic MEM_ACK,
    input wire logic [15:0] MEM_RDATA,
    output logic MEM_REQ,
    output logic MEM_WRITE,
    output logic [31:0] MEM_ADDR,
    output logic [1:0] MEM_BE,
    output logic [15:0] MEM_WDATA,
    output logic TXF_PUSH,
    output logic TXF_PUSH_TWO,
    output logic [15:0] TXF_CHARS,
    output logic RXF_POP,
    output logic RXF_POP_TWO,
    output logic [31:0] TX_ADDR,
    output logic [15:0] TX_COUNT,
    output logic [31:0] RX_ADDR,
    output logic [15:0] RX_COUNT,
    output sdbt_pkg::sdbt_status_t TX_STATUS,
    output sdbt_pkg::sdbt_status_t RX_STATUS,
    output logic [1:0] BUF_END,
    output logic UPPER_LANE_FIRST
);

`include "sdbt_map.svh"

    // ************
    // declarations
    // ************
    sdbt_pkg::sdbt_core_t st_reg;
    sdbt_pkg::sdbt_core_t st_next;
    sdbt_pkg::sdbt_mode_t [1:0] mode_c;
    logic [1:0] req_c;
    logic [1:0] avail2_c;
    logic [1:0] target_c;
    logic [1:0] start_c;
    logic [1:0] stop_c;
    logic [1:0] single_c;
    logic [1:0] can_wide_c;
    logic [1:0] hi_lane_c;
    logic [1:0] cnt_zero_c;
    logic [1:0] want_c;
    logic [1:0] grant_c;
    logic [1:0] term_evt_c;
    logic [1:0] ack_c;
    logic [31:0] addr_next_c [2];
    logic [15:0] count_next_c [2];
    logic stop_cmd;
    logic sync_mode;
    logic bound_mode;
    logic tx_one_left;
    logic tx_term;
    logic rx_bound_stored;

    // ************
    // shared decode
    // ************
    assign mode_c = {RX_MODE, TX_MODE};
    assign stop_cmd = (DMA_CMD == sdbt_pkg::DC_RESET) | (DMA_CMD == sdbt_pkg::DC_PAUSE) |
        (DMA_CMD == sdbt_pkg::DC_ABORT); // RL15
    // all but async is sync
    assign sync_mode = (SERIAL_MODE != sdbt_pkg::SM_ASYNC);
    // modes marking frame ends
    assign bound_mode = (SERIAL_MODE == sdbt_pkg::SM_BIT_ORIENTED) |
        (SERIAL_MODE == sdbt_pkg::SM_ETHERNET) |
        (SERIAL_MODE == sdbt_pkg::SM_TRANSPARENT_BISYNC) |
        (SERIAL_MODE == sdbt_pkg::SM_MIL_1553);

    // serial side requests
    assign req_c[`SDBT_CH_TX] = TX_REQ; // RL12
    assign req_c[`SDBT_CH_RX] = RX_REQ | st_reg.forced_rx; // RL18 RL19
    assign avail2_c[`SDBT_CH_TX] = TXF_ROOM2;
    assign avail2_c[`SDBT_CH_RX] = RXF_TWO;

    // bus completions
    assign ack_c[`SDBT_CH_TX] = (st_reg.ch[`SDBT_CH_TX].st == sdbt_pkg::ST_BUS) & MEM_ACK;
    assign ack_c[`SDBT_CH_RX] = (st_reg.ch[`SDBT_CH_RX].st == sdbt_pkg::ST_BUS) & MEM_ACK;

    // tx: one char left, low lane only
    assign tx_one_left = (TX_CHAR_COUNT == `SDBT_COUNT_ONE); // RL11
    // tx end as char counter hits zero
    assign tx_term = sync_mode & ack_c[`SDBT_CH_TX] &
        ((TX_CHAR_COUNT == `SDBT_COUNT_ONE) |
        (st_reg.mem_wide & (TX_CHAR_COUNT == `SDBT_COUNT_TWO))); // RL17
    // rx: boundary char stored now
    assign rx_bound_stored = ack_c[`SDBT_CH_RX] &
        (RXF_BOUND[0] | (st_reg.mem_wide & RXF_BOUND[1])); // RL18
    assign term_evt_c[`SDBT_CH_TX] = tx_term;
    assign term_evt_c[`SDBT_CH_RX] = rx_bound_stored | RX_TERM;

    // ************
    // per channel width, lane and step logic
    // ************
    for (genvar g = 0; g < 2; g++) begin : g_ch
        logic byte_only;
        logic [31:0] astep;
        logic [15:0] cstep;
        assign target_c[g] = DMA_CMD_ALL | ((g == `SDBT_CH_RX) ? DMA_CMD_RX : ~DMA_CMD_RX);
        assign start_c[g] = (DMA_CMD == sdbt_pkg::DC_START) & target_c[g];
        assign stop_c[g] = (stop_cmd & target_c[g]) | ~ABORT_B; // RL14 RL15
        assign single_c[g] = (mode_c[g].dma_major_mode == `SDBT_MODE_SINGLE); // RL23
        // narrow bus or forced bytes
        assign byte_only = ~WIDE_BUS_SELECT | mode_c[g].force_byte; // RL1
        // word: even address, two bytes left
        assign can_wide_c[g] = ~byte_only & ~st_reg.ch[g].addr[0] &
            (st_reg.ch[g].count >= `SDBT_COUNT_TWO) & avail2_c[g]; // RL6 RL7
        // addr bit 0 and lane order pick lane
        assign hi_lane_c[g] = WIDE_BUS_SELECT &
            (st_reg.ch[g].addr[0] ^ st_reg.upper_first); // RL5 RL7
        assign cnt_zero_c[g] = (st_reg.ch[g].count == `SDBT_COUNT_ZERO);
        // step by issued width
        assign astep = st_reg.mem_wide ? `SDBT_ADDR_WORD : `SDBT_ADDR_BYTE; // RL2 RL8
        assign cstep = st_reg.mem_wide ? `SDBT_COUNT_TWO : `SDBT_COUNT_ONE; // RL2 RL8
        // count saturates at zero
        assign count_next_c[g] = (st_reg.ch[g].count > cstep) ?
            (st_reg.ch[g].count - cstep) : `SDBT_COUNT_ZERO; // RL25
        always_comb begin
            case (mode_c[g].step)
                sdbt_pkg::STEP_INC: addr_next_c[g] = st_reg.ch[g].addr + astep;
                sdbt_pkg::STEP_DEC: addr_next_c[g] = st_reg.ch[g].addr - astep;
                default: addr_next_c[g] = st_reg.ch[g].addr;
            endcase
        end
        // ready to issue a transfer
        assign want_c[g] = (st_reg.ch[g].st == sdbt_pkg::ST_WAIT) & ~cnt_zero_c[g] &
            ~st_reg.ch[g].term_pend & req_c[g] & ~st_reg.mem_req & ~stop_c[g]; // RL12
    end

    // receive wins the bus over transmit
    assign grant_c[`SDBT_CH_RX] = want_c[`SDBT_CH_RX];
    assign grant_c[`SDBT_CH_TX] = want_c[`SDBT_CH_TX] & ~want_c[`SDBT_CH_RX];

    // ************
    // next state
    // ************
    always_comb begin
        st_next = st_reg;
        st_next.end_pulse = 2'h0;
        st_next.push = 1'b0;
        st_next.push_two = 1'b0;
        st_next.pop = 1'b0;
        st_next.pop_two = 1'b0;
        // lane order command, latest one wins
        if (CHAN_CMD == sdbt_pkg::CC_UPPER_FIRST) begin
            st_next.upper_first = 1'b1; // RL5
        end else if (CHAN_CMD == sdbt_pkg::CC_LOWER_FIRST) begin
            st_next.upper_first = 1'b0; // RL5
        end
        for (int c = 0; c < 2; c++) begin
            case (st_reg.ch[c].st)
                sdbt_pkg::ST_IDLE: begin
                    // load only while idle
                    if (LOAD_EN[c]) begin
                        st_next.ch[c].addr = LOAD_ADDR; // RL20
                        st_next.ch[c].count = LOAD_COUNT; // RL20
                    end
                    // only single buffer mode can be launched
                    if (start_c[c] & single_c[c]) begin
                        st_next.ch[c].st = sdbt_pkg::ST_WAIT; // RL20 RL23
                        st_next.ch[c].done = 1'b0;
                        st_next.ch[c].stopped = 1'b0;
                        st_next.ch[c].term_pend = 1'b0;
                    end
                end
                sdbt_pkg::ST_WAIT: begin
                    if (cnt_zero_c[c] | st_reg.ch[c].term_pend) begin
                        // buffer over, keep end values
                        st_next.ch[c].st = sdbt_pkg::ST_IDLE; // RL12 RL16 RL21 RL24
                        st_next.ch[c].done = 1'b1; // RL22
                        st_next.ch[c].term_pend = 1'b0;
                        st_next.end_pulse[c] = 1'b1; // RL22
                    end else if (grant_c[c]) begin
                        st_next.ch[c].st = sdbt_pkg::ST_BUS;
                        st_next.mem_req = 1'b1;
                        st_next.mem_write = (c == `SDBT_CH_RX);
                        st_next.mem_owner = (c == `SDBT_CH_RX);
                        st_next.mem_addr = st_reg.ch[c].addr;
                        st_next.mem_wide = can_wide_c[c];
                        st_next.mem_hi = hi_lane_c[c];
                        if (can_wide_c[c]) begin
                            st_next.mem_be = `SDBT_BE_BOTH; // RL6
                        end else if (!WIDE_BUS_SELECT) begin
                            st_next.mem_be = `SDBT_BE_LOW; // RL3
                        end else if ((c == `SDBT_CH_TX) &&
                            (mode_c[c].step != sdbt_pkg::STEP_HOLD)) begin
                            st_next.mem_be = `SDBT_BE_BOTH; // RL4
                        end else if (hi_lane_c[c]) begin
                            st_next.mem_be = `SDBT_BE_HIGH; // RL4 RL7
                        end else begin
                            st_next.mem_be = `SDBT_BE_LOW; // RL4 RL7
                        end
                        // oldest char goes on the even-addressed lane
                        if (can_wide_c[c] && st_reg.upper_first) begin
                            st_next.mem_wdata = {RXF_CHAR0, RXF_CHAR1}; // RL9 RL10
                        end else if (can_wide_c[c]) begin
                            st_next.mem_wdata = {RXF_CHAR1, RXF_CHAR0}; // RL9 RL10
                        end else begin
                            st_next.mem_wdata = {RXF_CHAR0, RXF_CHAR0};
                        end
                    end
                end
                sdbt_pkg::ST_BUS: begin
                    if (MEM_ACK) begin
                        st_next.ch[c].st = sdbt_pkg::ST_WAIT;
                        st_next.ch[c].count = count_next_c[c]; // RL2 RL8
                        st_next.ch[c].addr = addr_next_c[c]; // RL2 RL8
                        st_next.mem_req = 1'b0;
                        if (c == `SDBT_CH_RX) begin
                            st_next.pop = 1'b1;
                            st_next.pop_two = st_reg.mem_wide;
                        end else if (st_reg.mem_wide && tx_one_left) begin
                            st_next.push = 1'b1;
                            st_next.push_chars = {8'h00, MEM_RDATA[7:0]}; // RL11
                        end else if (st_reg.mem_wide && st_reg.upper_first) begin
                            st_next.push = 1'b1;
                            st_next.push_two = 1'b1;
                            st_next.push_chars = {MEM_RDATA[7:0], MEM_RDATA[15:8]}; // RL9
                        end else if (st_reg.mem_wide) begin
                            st_next.push = 1'b1;
                            st_next.push_two = 1'b1;
                            st_next.push_chars = MEM_RDATA; // RL9
                        end else begin
                            st_next.push = 1'b1;
                            st_next.push_chars = st_reg.mem_hi ?
                                {8'h00, MEM_RDATA[15:8]} : {8'h00, MEM_RDATA[7:0]}; // RL4
                        end
                    end
                end
                default: begin
                    st_next.ch[c].st = sdbt_pkg::ST_IDLE;
                end
            endcase
            // serial termination when enabled
            if (term_evt_c[c] && mode_c[c].early_termination_enable &&
                (st_reg.ch[c].st != sdbt_pkg::ST_IDLE)) begin
                st_next.ch[c].term_pend = 1'b1; // RL13
            end
            // summary stop: no end pulse, no further bus action
            if (stop_c[c] && (st_reg.ch[c].st != sdbt_pkg::ST_IDLE)) begin
                st_next.ch[c].st = sdbt_pkg::ST_IDLE; // RL14 RL15
                st_next.ch[c].stopped = 1'b1;
                st_next.ch[c].term_pend = 1'b0;
                st_next.end_pulse[c] = 1'b0;
                st_next.push = (c == `SDBT_CH_TX) ? 1'b0 : st_next.push;
                st_next.push_two = (c == `SDBT_CH_TX) ? 1'b0 : st_next.push_two;
                st_next.pop = (c == `SDBT_CH_RX) ? 1'b0 : st_next.pop;
                st_next.pop_two = (c == `SDBT_CH_RX) ? 1'b0 : st_next.pop_two;
                if (st_reg.ch[c].st == sdbt_pkg::ST_BUS) begin
                    st_next.mem_req = 1'b0;
                end
            end
            // reset command also clears the end flags
            if ((DMA_CMD == sdbt_pkg::DC_RESET) && target_c[c]) begin
                st_next.ch[c].done = 1'b0; // RL15
                st_next.ch[c].stopped = 1'b0;
            end
        end
        // forced rx request: set wins
        if (rx_bound_stored) begin
            st_next.forced_rx = 1'b0; // RL18
        end
        if (RXF_BOUND_IN && bound_mode) begin
            st_next.forced_rx = 1'b1; // RL18
        end
    end

    // ************
    // state register
    // ************
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            for (int c = 0; c < 2; c++) begin
                st_reg.ch[c].st <= sdbt_pkg::ST_IDLE;
                st_reg.ch[c].addr <= `SDBT_ADDR_RESET;
                st_reg.ch[c].count <= `SDBT_COUNT_ZERO;
                st_reg.ch[c].term_pend <= 1'b0;
                st_reg.ch[c].done <= 1'b0;
                st_reg.ch[c].stopped <= 1'b0;
            end
            st_reg.upper_first <= 1'b0;
            st_reg.forced_rx <= 1'b0;
            st_reg.mem_req <= 1'b0;
            st_reg.mem_write <= 1'b0;
            st_reg.mem_wide <= 1'b0;
            st_reg.mem_hi <= 1'b0;
            st_reg.mem_owner <= 1'b0;
            st_reg.mem_be <= 2'h0;
            st_reg.mem_addr <= `SDBT_ADDR_RESET;
            st_reg.mem_wdata <= `SDBT_DATA_RESET;
            st_reg.end_pulse <= 2'h0;
            st_reg.push <= 1'b0;
            st_reg.push_two <= 1'b0;
            st_reg.push_chars <= `SDBT_DATA_RESET;
            st_reg.pop <= 1'b0;
            st_reg.pop_two <= 1'b0;
        end else begin
            st_reg <= st_next;
        end
    end

    // ************
    // outputs
    // ************
    // bus and fifo strokes from register
    assign MEM_REQ = st_reg.mem_req;
    assign MEM_WRITE = st_reg.mem_write;
    assign MEM_ADDR = st_reg.mem_addr;
    assign MEM_BE = st_reg.mem_be;
    assign MEM_WDATA = st_reg.mem_wdata;
    assign TXF_PUSH = st_reg.push;
    assign TXF_PUSH_TWO = st_reg.push_two;
    assign TXF_CHARS = st_reg.push_chars;
    assign RXF_POP = st_reg.pop;
    assign RXF_POP_TWO = st_reg.pop_two;

    // read-back of ending address, count and status
    assign TX_ADDR = st_reg.ch[`SDBT_CH_TX].addr; // RL21
    assign TX_COUNT = st_reg.ch[`SDBT_CH_TX].count; // RL21
    assign RX_ADDR = st_reg.ch[`SDBT_CH_RX].addr; // RL21
    assign RX_COUNT = st_reg.ch[`SDBT_CH_RX].count; // RL21
    assign TX_STATUS = {(st_reg.ch[`SDBT_CH_TX].st != sdbt_pkg::ST_IDLE),
        st_reg.ch[`SDBT_CH_TX].done, st_reg.ch[`SDBT_CH_TX].stopped}; // RL22
    assign RX_STATUS = {(st_reg.ch[`SDBT_CH_RX].st != sdbt_pkg::ST_IDLE),
        st_reg.ch[`SDBT_CH_RX].done, st_reg.ch[`SDBT_CH_RX].stopped}; // RL22
    assign BUF_END = st_reg.end_pulse; // RL22
    assign UPPER_LANE_FIRST = st_reg.upper_first;

endmodule // sdbt_core

// ### hdl/sdbt_map.svh
// sdbt_map.svh: codes, reset values and limits of the serial dma buffer core
`ifndef SDBT_MAP_SVH
`define SDBT_MAP_SVH

// ************
// major mode codes
// ************
`define SDBT_MODE_SINGLE 2'h0
`define SDBT_MODE_PIPE 2'h1
`define SDBT_MODE_ARRAY 2'h2
`define SDBT_MODE_LIST 2'h3

// ************
// channel indices and byte lane enables
// ************
`define SDBT_CH_TX 0
`define SDBT_CH_RX 1
`define SDBT_BE_LOW 2'h1
`define SDBT_BE_HIGH 2'h2
`define SDBT_BE_BOTH 2'h3

// ************
// counts, steps and reset values
// ************
`define SDBT_COUNT_ZERO 16'h0000
`define SDBT_COUNT_ONE 16'h0001
`define SDBT_COUNT_TWO 16'h0002
`define SDBT_ADDR_BYTE 32'h00000001
`define SDBT_ADDR_WORD 32'h00000002
`define SDBT_ADDR_RESET 32'h00000000
`define SDBT_DATA_RESET 16'h0000

`endif

// ### hdl/sdbt_pkg.sv
// sdbt_pkg.sv: types of the serial dma buffer core
package sdbt_pkg;

    // ************
    // modes and commands
    // ************
    typedef enum logic [1:0] {STEP_INC, STEP_HOLD, STEP_DEC} sdbt_step_t;
    typedef enum logic [2:0] {DC_NONE, DC_START, DC_RESET, DC_PAUSE, DC_ABORT} sdbt_dma_cmd_t;
    typedef enum logic [1:0] {CC_NONE, CC_UPPER_FIRST, CC_LOWER_FIRST} sdbt_chan_cmd_t;
    typedef enum logic [2:0] {
        SM_ASYNC, SM_SYNC, SM_BIT_ORIENTED, SM_ETHERNET, SM_TRANSPARENT_BISYNC, SM_MIL_1553
    } sdbt_serial_mode_t;
    typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_BUS} sdbt_state_t;

    // ************
    // carriers
    // ************
    typedef struct packed {
        logic [1:0] dma_major_mode;
        logic force_byte;
        logic early_termination_enable;
        sdbt_step_t step;
    } sdbt_mode_t;

    typedef struct packed {
        logic busy;
        logic done;
        logic stopped;
    } sdbt_status_t;

    typedef struct packed {
        sdbt_state_t st;
        logic [31:0] addr;
        logic [15:0] count;
        logic term_pend;
        logic done;
        logic stopped;
    } sdbt_chan_t;

    typedef struct packed {
        sdbt_chan_t [1:0] ch;
        logic upper_first;
        logic forced_rx;
        logic mem_req;
        logic mem_write;
        logic mem_wide;
        logic mem_hi;
        logic mem_owner;
        logic [1:0] mem_be;
        logic [31:0] mem_addr;
        logic [15:0] mem_wdata;
        logic [1:0] end_pulse;
        logic push;
        logic push_two;
        logic [15:0] push_chars;
        logic pop;
        logic pop_two;
    } sdbt_core_t;

endpackage

// ### testbench/sdbt_core_properties.sv
// sdbt_core_properties.sv: port checks of the dma core
`timescale 1ns/1ns
module sdbt_core_properties (
    input wire logic CORE_CLK,
    input wire logic RST_B,
    input wire logic WIDE_BUS_SELECT,
    input wire sdbt_pkg::sdbt_mode_t TX_MODE,
    input wire sdbt_pkg::sdbt_dma_cmd_t DMA_CMD,
    input wire logic DMA_CMD_ALL,
    input wire logic DMA_CMD_RX,
    input wire logic ABORT_B,
    input wire logic MEM_ACK,
    input wire logic MEM_REQ,
    input wire logic MEM_WRITE,
    input wire logic [31:0] MEM_ADDR,
    input wire logic [1:0] MEM_BE,
    input wire logic [15:0] TX_COUNT,
    input wire logic [15:0] RX_COUNT,
    input wire sdbt_pkg::sdbt_status_t TX_STATUS,
    input wire logic [1:0] BUF_END
);
    default clocking @(posedge CORE_CLK);
    endclocking
    default disable iff (!RST_B);
    a_narrow_low_lane: assert property (MEM_REQ && !WIDE_BUS_SELECT |-> MEM_BE == 2'h1)
        else $error("narrow bus lane wrong");
    a_forced_both_lanes: assert property (MEM_REQ && !MEM_WRITE && WIDE_BUS_SELECT
        && TX_MODE.force_byte && TX_MODE.step != sdbt_pkg::STEP_HOLD |-> MEM_BE == 2'h3)
        else $error("forced tx byte not on both lanes");
    a_byte_count_one: assert property (MEM_REQ && MEM_ACK && !MEM_WRITE && TX_MODE.force_byte
        |=> TX_COUNT == $past(TX_COUNT) - 16'h1) else $error("tx byte count step wrong");
    a_word_count_two: assert property (MEM_REQ && MEM_ACK && MEM_WRITE && MEM_BE == 2'h3
        |=> RX_COUNT == $past(RX_COUNT) - 16'h2) else $error("rx word count step wrong");
    a_word_when_able: assert property (MEM_REQ && MEM_WRITE && MEM_BE == 2'h3
        |-> WIDE_BUS_SELECT && !MEM_ADDR[0] && RX_COUNT >= 16'h2) else $error("bad word");
    a_end_pulse_done: assert property (BUF_END[0] |-> TX_STATUS.done ##1 !BUF_END[0])
        else $error("tx end pulse or done wrong");
    a_abort_stops_now: assert property (!ABORT_B |=> !MEM_REQ && BUF_END == 2'h0)
        else $error("abort did not stop");
    a_stop_cmd_tx: assert property (DMA_CMD inside {sdbt_pkg::DC_RESET, sdbt_pkg::DC_PAUSE,
        sdbt_pkg::DC_ABORT} && (DMA_CMD_ALL || !DMA_CMD_RX) |=> !TX_STATUS.busy && BUF_END == 2'h0)
        else $error("stop command ignored");
endmodule // sdbt_core_properties
bind sdbt_core sdbt_core_properties chk_u (.*);

// ### testbench/sdbt_mem_model.sv
// sdbt_mem_model.sv: system memory answering the channel bus cycles
`timescale 1ns/1ns
module sdbt_mem_model (
    input wire logic CORE_CLK,
    input wire logic RST_B,
    input wire logic MEM_REQ,
    input wire logic [31:0] MEM_ADDR,
    input wire logic SLOW,
    output logic MEM_ACK,
    output logic [15:0] MEM_RDATA
);
    logic [1:0] wait_reg;
    // one ack per cycle after 0 or 2 waits, data churns outside cycles
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            wait_reg <= 2'h0;
            MEM_ACK <= 1'b0;
            MEM_RDATA <= 16'h0000;
        end else begin
            MEM_ACK <= MEM_REQ && !MEM_ACK && (!SLOW || wait_reg == 2'h2);
            wait_reg <= (MEM_REQ && !MEM_ACK) ? wait_reg + 2'h1 : 2'h0;
            MEM_RDATA <= (MEM_REQ && !MEM_ACK) ? {~MEM_ADDR[7:0], MEM_ADDR[7:0]} : ~MEM_RDATA;
        end
    end
endmodule // sdbt_mem_model

// ### testbench/test_serial_dma_buffer_transfer.sv
// test_serial_dma_buffer_transfer.sv: directed bench of the dma core
`timescale 1ns/1ns
module test_serial_dma_buffer_transfer;
    logic CORE_CLK = 1'b0, RST_B = 1'b0, WIDE_BUS_SELECT, DMA_CMD_ALL, DMA_CMD_RX, ABORT_B;
    logic TX_REQ, TXF_ROOM2, RX_REQ, RXF_TWO, RXF_BOUND_IN, RX_TERM, MEM_ACK, MEM_REQ, slow, seen;
    logic MEM_WRITE, TXF_PUSH, TXF_PUSH_TWO, RXF_POP, RXF_POP_TWO, UPPER_LANE_FIRST;
    logic [1:0] LOAD_EN, RXF_BOUND, MEM_BE, BUF_END;
    logic [7:0] RXF_CHAR0, RXF_CHAR1;
    logic [15:0] LOAD_COUNT, TX_CHAR_COUNT, MEM_RDATA, MEM_WDATA, TXF_CHARS, TX_COUNT, RX_COUNT;
    logic [31:0] LOAD_ADDR, MEM_ADDR, TX_ADDR, RX_ADDR;
    sdbt_pkg::sdbt_mode_t TX_MODE, RX_MODE;
    sdbt_pkg::sdbt_serial_mode_t SERIAL_MODE;
    sdbt_pkg::sdbt_dma_cmd_t DMA_CMD;
    sdbt_pkg::sdbt_chan_cmd_t CHAN_CMD;
    sdbt_pkg::sdbt_status_t TX_STATUS, RX_STATUS;
    int errors = 0, cmp_count = 0, cycles = 0, pushed = 0;
    logic [3:0] tx_wide = 4'hE, tx_force = 4'h6, tx_dec = 4'h4;
    logic [15:0] tx_cnt [4] = '{16'h3, 16'h2, 16'h2, 16'h4};
    logic [31:0] tx_addr [4] = '{32'h10, 32'h21, 32'h40, 32'h31};
    logic [31:0] tx_end [4] = '{32'h13, 32'h23, 32'h3E, 32'h35};
    sdbt_pkg::sdbt_dma_cmd_t stops [3] = '{sdbt_pkg::DC_RESET, sdbt_pkg::DC_PAUSE, sdbt_pkg::DC_ABORT};
    sdbt_core dut_u (.*);
    sdbt_mem_model mem_u (.CORE_CLK, .RST_B, .MEM_REQ, .MEM_ADDR, .SLOW(slow), .MEM_ACK, .MEM_RDATA);
    // clock, cycle ceiling and tally of pushed characters
    always #5 CORE_CLK = ~CORE_CLK;
    always @(negedge CORE_CLK) begin
        cycles++;
        pushed += (TXF_PUSH === 1'b1) ? 1 + int'(TXF_PUSH_TWO) : 0;
        if (cycles == 20000) begin
            errors++;
            tally_and_finish();
        end
    end
    task automatic chk(input string what, input logic [63:0] got, input logic [63:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tally_and_finish();
        $display("errors %0d compares %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // load one channel and start it
    task automatic go(input logic ch, input logic [31:0] addr, input logic [15:0] cnt);
        @(negedge CORE_CLK);
        LOAD_EN = 2'h1 << ch;
        LOAD_ADDR = addr;
        LOAD_COUNT = cnt;
        @(negedge CORE_CLK);
        LOAD_EN = 2'h0;
        DMA_CMD = sdbt_pkg::DC_START;
        DMA_CMD_RX = ch;
        @(negedge CORE_CLK);
        DMA_CMD = sdbt_pkg::DC_NONE;
    endtask
    // bounded waits for a buffer end or a bus cycle
    task automatic wait_end(input int ch);
        seen = 1'b0;
        for (int i = 0; i < 100 && !seen; i++) begin
            @(negedge CORE_CLK);
            seen = BUF_END[ch] === 1'b1;
        end
    endtask
    task automatic wait_bus(input logic need_ack);
        for (int i = 0; i < 50 && !(MEM_REQ === 1'b1 && (!need_ack || MEM_ACK === 1'b1)); i++)
            @(negedge CORE_CLK);
    endtask
    initial begin
        {WIDE_BUS_SELECT, DMA_CMD_ALL, DMA_CMD_RX, TX_REQ, RX_REQ, RXF_BOUND_IN, RX_TERM} = 7'h0;
        {slow, LOAD_EN, RXF_BOUND, LOAD_COUNT, TX_CHAR_COUNT, LOAD_ADDR} = '0;
        {TXF_ROOM2, RXF_TWO, ABORT_B, RXF_CHAR1, RXF_CHAR0} = 19'h72211;
        {TX_MODE, RX_MODE} = '0;
        SERIAL_MODE = sdbt_pkg::SM_ASYNC;
        DMA_CMD = sdbt_pkg::DC_NONE;
        CHAN_CMD = sdbt_pkg::CC_NONE;
        repeat (8) @(posedge CORE_CLK);
        @(negedge CORE_CLK);
        RST_B = 1'b1;
        // tx buffers: narrow, forced bytes up and down, byte word byte mix
        for (int i = 0; i < 4; i++) begin
            WIDE_BUS_SELECT = tx_wide[i];
            TX_MODE.force_byte = tx_force[i];
            TX_MODE.step = sdbt_pkg::sdbt_step_t'(tx_dec[i] ? 2'h2 : 2'h0);
            pushed = 0;
            TX_REQ = 1'b1;
            go(1'b0, tx_addr[i], tx_cnt[i]);
            wait_end(0);
            chk("tx end", seen, 1'h1);
            chk("tx count", TX_COUNT, 16'h0);
            chk("tx addr", TX_ADDR, tx_end[i]);
            chk("tx chars", pushed, tx_cnt[i]);
            chk("tx status", TX_STATUS, 3'h2);
        end
        // rx word then last byte under both lane orders
        RX_REQ = 1'b1;
        for (int u = 0; u < 2; u++) begin
            CHAN_CMD = sdbt_pkg::sdbt_chan_cmd_t'(u ? 2'h1 : 2'h2);
            @(negedge CORE_CLK);
            CHAN_CMD = sdbt_pkg::CC_NONE;
            chk("lane order", UPPER_LANE_FIRST, u[0]);
            go(1'b1, 32'h50, 16'h3);
            wait_bus(1'b1);
            chk("rx word", {MEM_BE, MEM_WDATA}, u ? 18'h31122 : 18'h32211);
            @(negedge CORE_CLK);
            wait_bus(1'b1);
            chk("rx byte lane", MEM_BE, u ? 2'h2 : 2'h1);
            wait_end(1);
            chk("rx end addr", {RX_COUNT, RX_ADDR}, 48'h53);
        end
        // rx termination ignored, then abort, then honoured
        RX_REQ = 1'b0;
        for (int e = 0; e < 2; e++) begin
            RX_MODE.early_termination_enable = e[0];
            go(1'b1, 32'h60, 16'h8);
            RX_TERM = 1'b1;
            @(negedge CORE_CLK);
            RX_TERM = 1'b0;
            wait_end(1);
            chk("rx early end", seen, e[0]);
            chk("rx count", RX_COUNT, 16'h8);
            ABORT_B = 1'b0;
            @(negedge CORE_CLK);
            ABORT_B = 1'b1;
            chk("rx status", RX_STATUS, e ? 3'h2 : 3'h1);
        end
        // zero count start moves nothing
        go(1'b0, 32'h70, 16'h0);
        wait_end(0);
        chk("zero end", {seen, TX_ADDR}, 33'h100000070);
        // stop commands cut a slow tx buffer short
        slow = 1'b1;
        for (int c = 0; c < 3; c++) begin
            go(1'b0, 32'h80, 16'h6);
            wait_bus(1'b0);
            DMA_CMD = stops[c];
            DMA_CMD_ALL = c == 2;
            @(negedge CORE_CLK);
            DMA_CMD = sdbt_pkg::DC_NONE;
            @(negedge CORE_CLK);
            chk("stop status", {TX_STATUS, TX_COUNT}, {c ? 3'h1 : 3'h0, 16'h6});
        end
        tally_and_finish();
    end
endmodule // test_serial_dma_buffer_transfer
